// ===== core/ivp_vector_logic.sv
// Purpose: Interrupt control registers and the service vector pointer of a processor core.
// Assumes: Core event strobes are one-cycle pulses on clk; interrupt pins are asynchronous.
// Notes: Reads return data one cycle after the select; flag changes show in reads two cycles after a write.
// Behaviour
// - The low five bits of the vector pointer always read as zero.
// - Bits 5 to 9 hold the index of the highest-priority pending and enabled interrupt.
// - With nothing pending and enabled the index field is zero.
// - The index ignores the global and nonmaskable enables, except that the nonmaskable interrupt needs its own.
// - The table base in bits 10 to 31 resets to zero and software may rewrite it.
// - Reset service is always fetched from address zero.
// - The pointer reads as base, then index, then five zero bits.
// - The pointer is readable over the control move path.
// - Writing ones to the flag-set register sets pending flags of interrupts 4 to 15.
// - Writing ones to the flag-clear register clears pending flags of interrupts 4 to 15.
// - A nonmaskable return pointer holds the resume address used to return from that service.
// - A maskable return pointer holds the resume address used to return from maskable service.
// - A global enable bit in the control status register gates maskable processing.
// - Priority runs reset, nonmaskable, then interrupts 4 to 15 in ascending order.
// - Service entries are 32 bytes apart.
`timescale 1ns/1ns
module ivp_vector_logic #(
  parameter int FW = ivp_pkg::FLAG_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [FW-1:0] intPin,
  input wire logic ctlWrEn,
  input wire logic [ivp_pkg::SEL_W-1:0] ctlWrSel,
  input wire logic [31:0] ctlWrData,
  input wire logic [ivp_pkg::SEL_W-1:0] ctlRdSel,
  output logic [31:0] ctlRdData,
  input wire logic nmiTaken,
  input wire logic intTaken,
  input wire logic [4:0] intTakenNum,
  input wire logic nmiReturn,
  input wire logic intReturn,
  input wire logic [31:0] resumeAddr,
  output logic [31:0] vectorPtr,
  output logic [31:0] nmiRetPtr,
  output logic [31:0] intRetPtr,
  output logic [31:0] resetEntryAddr,
  output logic globalEnable,
  output logic nmiEnable,
  output logic maskableReady
);
  logic [FW-1:0] pinMeta_r, pinSync_r, pinOld_r;
  logic [FW-1:0] flag_r, flag_nxt, enable_r, enable_nxt;
  logic globEn_r, globEn_nxt, prevGlobEn_r, prevGlobEn_nxt;
  logic [21:0] base_r, base_nxt;
  logic [31:0] vec_r, vec_nxt, nmiRet_r, nmiRet_nxt, intRet_r, intRet_nxt, rd_r, rd_nxt, rst_entry_r;
  logic ready_r, ready_nxt;
  logic [FW-1:0] rise, setBits, clrBits, qual, takenClr;
  logic [4:0] topIdx;
  logic topFound;
  logic wrSet, wrClear, wrEnable, wrStatus, wrVtp, wrNmiRet, wrIntRet;

  // Pin synchroniser; only the second stage feeds the edge detector.
  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
      pinOld_r <= '0;
    end else begin
      pinMeta_r <= intPin;
      pinSync_r <= pinMeta_r;
      pinOld_r <= pinSync_r;
    end
  end

  // Pending and enabled requests; the nonmaskable bit is qualified by its own enable.
  assign qual = flag_r & enable_r & ivp_pkg::FLAG_MASK;
  ivp_low_index #(.W(FW), .IW(5)) u_top (
    .req(qual),
    .idx(topIdx),
    .found(topFound)
  );

  // Write decode and flag set and clear terms.
  always_comb begin
    wrSet = ctlWrEn && ctlWrSel == ivp_pkg::SEL_SET;
    wrClear = ctlWrEn && ctlWrSel == ivp_pkg::SEL_CLEAR;
    wrEnable = ctlWrEn && ctlWrSel == ivp_pkg::SEL_ENABLE;
    wrStatus = ctlWrEn && ctlWrSel == ivp_pkg::SEL_STATUS;
    wrVtp = ctlWrEn && ctlWrSel == ivp_pkg::SEL_VTP;
    wrNmiRet = ctlWrEn && ctlWrSel == ivp_pkg::SEL_NMI_RET;
    wrIntRet = ctlWrEn && ctlWrSel == ivp_pkg::SEL_INT_RET;
    rise = pinSync_r & ~pinOld_r & ivp_pkg::FLAG_MASK;
    takenClr = '0;
    if (intTaken) begin
      takenClr[intTakenNum[3:0]] = 1'b1;
    end
    if (nmiTaken) begin
      takenClr[ivp_pkg::NMI_BIT] = 1'b1;
    end
    setBits = rise | ((wrSet ? ctlWrData[FW-1:0] : '0) & ivp_pkg::IE_WMASK);
    clrBits = ((wrClear ? ctlWrData[FW-1:0] : '0) & ivp_pkg::IE_WMASK) | takenClr;
  end

  // Next values of all control registers.
  always_comb begin
    flag_nxt = ((flag_r & ~clrBits) | setBits) & ivp_pkg::FLAG_MASK;
    enable_nxt = enable_r;
    if (wrEnable) begin
      enable_nxt = (enable_r & ~ivp_pkg::IE_WMASK) | (ctlWrData[FW-1:0] & ivp_pkg::IE_WMASK);
      if (ctlWrData[ivp_pkg::NMI_BIT]) begin
        enable_nxt[ivp_pkg::NMI_BIT] = 1'b1;
      end
    end
    if (nmiReturn) begin
      enable_nxt[ivp_pkg::NMI_BIT] = 1'b1;
    end
    if (nmiTaken) begin
      enable_nxt[ivp_pkg::NMI_BIT] = 1'b0;
    end
    globEn_nxt = wrStatus ? ctlWrData[ivp_pkg::GLOBAL_BIT] : globEn_r;
    prevGlobEn_nxt = wrStatus ? ctlWrData[ivp_pkg::PREV_GLOBAL_BIT] : prevGlobEn_r;
    if (intReturn) begin
      globEn_nxt = prevGlobEn_r;
    end
    if (intTaken) begin
      prevGlobEn_nxt = globEn_nxt;
      globEn_nxt = 1'b0;
    end
    base_nxt = wrVtp ? ctlWrData[31:ivp_pkg::BASE_LO] : base_r;
    vec_nxt = {base_r, (topFound ? topIdx : 5'h00), 5'h00};
    nmiRet_nxt = nmiTaken ? resumeAddr : (wrNmiRet ? ctlWrData : nmiRet_r);
    intRet_nxt = intTaken ? resumeAddr : (wrIntRet ? ctlWrData : intRet_r);
    ready_nxt = globEn_r && enable_r[ivp_pkg::NMI_BIT] && ((qual & ivp_pkg::IE_WMASK) != '0);
    unique case (ctlRdSel)
      ivp_pkg::SEL_STATUS: rd_nxt = {30'h0, prevGlobEn_r, globEn_r};
      ivp_pkg::SEL_ENABLE: rd_nxt = {16'h0000, enable_r | 16'h0001};
      ivp_pkg::SEL_FLAG: rd_nxt = {16'h0000, flag_r};
      ivp_pkg::SEL_VTP: rd_nxt = vec_r;
      ivp_pkg::SEL_NMI_RET: rd_nxt = nmiRet_r;
      ivp_pkg::SEL_INT_RET: rd_nxt = intRet_r;
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Register stage for all control state.
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= ivp_pkg::FLAG_RST;
      enable_r <= ivp_pkg::ENABLE_RST;
      globEn_r <= 1'b0;
      prevGlobEn_r <= 1'b0;
      base_r <= ivp_pkg::BASE_RST;
      vec_r <= ivp_pkg::PTR_RST;
      nmiRet_r <= ivp_pkg::PTR_RST;
      intRet_r <= ivp_pkg::PTR_RST;
      rd_r <= ivp_pkg::PTR_RST;
      ready_r <= 1'b0;
      rst_entry_r <= ivp_pkg::RESET_ENTRY;
    end else begin
      flag_r <= flag_nxt;
      enable_r <= enable_nxt;
      globEn_r <= globEn_nxt;
      prevGlobEn_r <= prevGlobEn_nxt;
      base_r <= base_nxt;
      vec_r <= vec_nxt;
      nmiRet_r <= nmiRet_nxt;
      intRet_r <= intRet_nxt;
      rd_r <= rd_nxt;
      ready_r <= ready_nxt;
      rst_entry_r <= ivp_pkg::RESET_ENTRY;
    end
  end

  // Outputs come straight from registers.
  assign ctlRdData = rd_r;
  assign vectorPtr = vec_r;
  assign nmiRetPtr = nmiRet_r;
  assign intRetPtr = intRet_r;
  assign resetEntryAddr = rst_entry_r;
  assign globalEnable = globEn_r;
  assign nmiEnable = enable_r[ivp_pkg::NMI_BIT];
  assign maskableReady = ready_r;

  // Helper copy of the qualified requests, aligned with the pointer register.
  logic [FW-1:0] qualPrev_r;
  always_ff @(posedge clk) begin
    qualPrev_r <= rst ? '0 : qual;
  end

  sequence vtpWrite_s;
    wrVtp ##1 !wrVtp;
  endsequence

  lowZero_a: assert property (@(posedge clk) disable iff (rst) vec_r[4:0] == 5'h00)
    else $error("Pointer low bits not zero.");
  topIndex_a: assert property (@(posedge clk) disable iff (rst)
    qualPrev_r != '0 |-> qualPrev_r[vec_r[8:5]] && (qualPrev_r & ((16'h0001 << vec_r[8:5]) - 16'h0001)) == '0)
    else $error("Index is not the highest priority request.");
  noneZero_a: assert property (@(posedge clk) disable iff (rst) qualPrev_r == '0 |-> vec_r[9:5] == 5'h00)
    else $error("Index not zero when nothing qualifies.");
  nmiQual_a: assert property (@(posedge clk) disable iff (rst)
    !enable_r[ivp_pkg::NMI_BIT] |=> vec_r[9:5] != 5'h01)
    else $error("Nonmaskable index without its enable.");
  baseWrite_a: assert property (@(posedge clk) disable iff (rst)
    vtpWrite_s |=> vec_r[31:10] == $past(ctlWrData[31:10], 2))
    else $error("Table base not taken into pointer.");
  resetEntry_a: assert property (@(posedge clk) disable iff (rst) resetEntryAddr == 32'h00000000)
    else $error("Reset entry not at zero.");
  ptrRead_a: assert property (@(posedge clk) disable iff (rst)
    ctlRdSel == ivp_pkg::SEL_VTP |=> ctlRdData == $past(vec_r))
    else $error("Pointer read mismatch.");
  flagSet_a: assert property (@(posedge clk) disable iff (rst)
    wrSet && ctlWrData[4] |=> flag_r[4])
    else $error("Flag set write lost.");
  flagClr_a: assert property (@(posedge clk) disable iff (rst)
    wrClear && ctlWrData[5] && !setBits[5] |=> !flag_r[5])
    else $error("Flag clear write lost.");
  nmiRet_a: assert property (@(posedge clk) disable iff (rst)
    nmiTaken |=> nmiRetPtr == $past(resumeAddr))
    else $error("Nonmaskable return pointer not loaded.");
  intRet_a: assert property (@(posedge clk) disable iff (rst)
    intTaken |=> intRetPtr == $past(resumeAddr))
    else $error("Maskable return pointer not loaded.");
  gieTaken_a: assert property (@(posedge clk) disable iff (rst)
    intTaken && !wrStatus && !intReturn |=> !globalEnable && prevGlobEn_r == $past(globEn_r))
    else $error("Global enable not saved and cleared.");
endmodule : ivp_vector_logic

// ===== core/ivp_pkg.sv
// Purpose: Shared constants for the interrupt vector pointer logic.
// Assumes: Control registers are selected by a small select code on the move path.
// Notes: Select codes are local to this block.
package ivp_pkg;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 16;
  localparam int SEL_W = 3;
  // Control register select codes.
  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_ENABLE = 3'h1;
  localparam logic [2:0] SEL_FLAG = 3'h2;
  localparam logic [2:0] SEL_SET = 3'h3;
  localparam logic [2:0] SEL_CLEAR = 3'h4;
  localparam logic [2:0] SEL_VTP = 3'h5;
  localparam logic [2:0] SEL_NMI_RET = 3'h6;
  localparam logic [2:0] SEL_INT_RET = 3'h7;
  // Field positions.
  localparam int GLOBAL_BIT = 0;
  localparam int PREV_GLOBAL_BIT = 1;
  localparam int RESET_BIT = 0;
  localparam int NMI_BIT = 1;
  localparam int IDX_LO = 5;
  localparam int IDX_W = 5;
  localparam int BASE_LO = 10;
  localparam int BASE_W = 22;
  // Flag bits that exist: the nonmaskable one and interrupts 4 to 15.
  localparam logic [15:0] FLAG_MASK = 16'hFFF2;
  // Enable bits that software may write directly (4 to 15).
  localparam logic [15:0] IE_WMASK = 16'hFFF0;
  // Reset values.
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [21:0] BASE_RST = 22'h000000;
  localparam logic [31:0] PTR_RST = 32'h00000000;
  localparam logic [31:0] RESET_ENTRY = 32'h00000000;
endpackage : ivp_pkg

// ===== core/ivp_low_index.sv
// Purpose: Finds the lowest set bit of a request vector, lowest index first.
// Assumes: Bit 0 is the highest priority.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module ivp_low_index #(
  parameter int W = 16,
  parameter int IW = 5
) (
  input wire logic [W-1:0] req,
  output logic [IW-1:0] idx,
  output logic found
);
  // Scan from the top down so the lowest set index is kept last.
  always_comb begin
    idx = '0;
    found = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = IW'(i);
        found = 1'b1;
      end
    end
  end
endmodule : ivp_low_index

// ===== verif/ivp_src_model.sv
// Purpose: Interrupt source model that raises interrupt pins for the vector logic.
// Assumes: Pins are active high and idle low between requests.
// Notes: A one-cycle request on fire holds the chosen pins high for five cycles.
`timescale 1ns/1ns
module ivp_src_model (
  input wire logic clk,
  input wire logic [15:0] fire,
  output logic [15:0] pins
);
  logic [2:0] holdCnt = 3'h0;
  logic [15:0] pinsHold_r = 16'h0000;
  // Stretches each request so the two-flop synchronizer sees a clean rising edge.
  always @(posedge clk) begin
    if (fire != 16'h0000) begin
      pinsHold_r <= fire;
      holdCnt <= 3'h4;
    end else if (holdCnt != 3'h0) begin
      holdCnt <= holdCnt - 3'h1;
    end else begin
      pinsHold_r <= 16'h0000; // Released pins return to their idle low level.
    end
  end
  // One driver for the pins, starting idle low.
  assign pins = pinsHold_r;
endmodule : ivp_src_model

// ===== verif/tb.sv
// Purpose: Self-checking bench for the interrupt vector pointer logic.
// Assumes: Control moves take one cycle; reads answer one cycle after the select.
// Notes: Table rows cover the index encoder; core events are tested by hand after them.
`timescale 1ns/1ns
module tb;
  typedef struct packed {logic [15:0] enMask; logic [15:0] setMask; logic [4:0] idx;} ivp_row_s;
  logic clk, rst, ctlWrEn, nmiTaken, intTaken, nmiReturn, intReturn, globalEnable, nmiEnable, maskableReady;
  logic [2:0] ctlWrSel, ctlRdSel;
  logic [4:0] intTakenNum;
  logic [15:0] intPin, fire;
  logic [31:0] ctlWrData, ctlRdData, resumeAddr, vectorPtr, nmiRetPtr, intRetPtr, resetEntryAddr, rdVal;
  int num_errors = 0;
  int compares = 0;
  ivp_row_s rows [5] = '{'{16'h1230, 16'hBBC0, 5'h09}, '{16'h0000, 16'hFFF0, 5'h00},
    '{16'h8000, 16'h8000, 5'h0F}, '{16'hFFF0, 16'hFFF0, 5'h04}, '{16'h0010, 16'h0000, 5'h00}};
  ivp_vector_logic ivp_vector_logic_inst (.clk(clk), .rst(rst), .intPin(intPin), .ctlWrEn(ctlWrEn),
    .ctlWrSel(ctlWrSel), .ctlWrData(ctlWrData), .ctlRdSel(ctlRdSel), .ctlRdData(ctlRdData),
    .nmiTaken(nmiTaken), .intTaken(intTaken), .intTakenNum(intTakenNum), .nmiReturn(nmiReturn),
    .intReturn(intReturn), .resumeAddr(resumeAddr), .vectorPtr(vectorPtr), .nmiRetPtr(nmiRetPtr),
    .intRetPtr(intRetPtr), .resetEntryAddr(resetEntryAddr), .globalEnable(globalEnable),
    .nmiEnable(nmiEnable), .maskableReady(maskableReady));
  ivp_src_model ivp_src_model_inst (.clk(clk), .fire(fire), .pins(intPin));
  // Free-running core clock of 4 ns.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task wr(input logic [2:0] sel, input logic [31:0] d);
    @(posedge clk);
    ctlWrEn <= 1'b1;
    ctlWrSel <= sel;
    ctlWrData <= d;
    @(posedge clk);
    ctlWrEn <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] sel);
    @(posedge clk);
    ctlRdSel <= sel;
    @(posedge clk);
    #1 rdVal = ctlRdData;
  endtask : rd
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  // Pulses one core event for a cycle: 0 nmi taken, 1 int taken, 2 nmi return, 3 int return.
  task ev(input int k, input logic [31:0] a);
    @(posedge clk);
    resumeAddr <= a;
    intTakenNum <= 5'h04;
    nmiTaken <= (k == 0);
    intTaken <= (k == 1);
    nmiReturn <= (k == 2);
    intReturn <= (k == 3);
    @(posedge clk);
    {nmiTaken, intTaken, nmiReturn, intReturn} <= 4'h0;
    settle;
  endtask : ev
  task conclude;
    $display("num_errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  // Cuts a hang short well beyond the expected 140 or so cycles.
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    conclude;
  end
  // Main sequence: reset, table rows, then hand-written cases.
  initial begin
    {rst, ctlWrEn, nmiTaken, intTaken, nmiReturn, intReturn} = 6'h20;
    {ctlWrSel, ctlRdSel, intTakenNum, fire, ctlWrData, resumeAddr} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    settle;
    chk(32'h00000000, vectorPtr);
    chk(32'h00000000, resetEntryAddr);
    chk(32'h00000000, {30'h0, nmiEnable, globalEnable});
    rd(ivp_pkg::SEL_ENABLE);
    chk(32'h00000001, rdVal);
    wr(ivp_pkg::SEL_VTP, 32'h00000800);
    foreach (rows[i]) begin
      wr(ivp_pkg::SEL_CLEAR, 32'h0000FFFF);
      wr(ivp_pkg::SEL_ENABLE, {16'h0000, rows[i].enMask});
      wr(ivp_pkg::SEL_SET, {16'h0000, rows[i].setMask});
      settle;
      chk({22'h2, rows[i].idx, 5'h00}, vectorPtr);
    end
    rd(ivp_pkg::SEL_VTP);
    chk(32'h00000800, rdVal);
    wr(ivp_pkg::SEL_SET, 32'h00000042);
    rd(ivp_pkg::SEL_FLAG);
    chk(32'h00000040, rdVal);
    rd(ivp_pkg::SEL_SET);
    chk(32'h00000000, rdVal);
    wr(ivp_pkg::SEL_CLEAR, 32'h00000040);
    rd(ivp_pkg::SEL_FLAG);
    chk(32'h00000000, rdVal);
    @(posedge clk);
    fire <= 16'h0012;
    @(posedge clk);
    fire <= 16'h0000;
    repeat (3) settle;
    chk(32'h00000880, vectorPtr);
    wr(ivp_pkg::SEL_ENABLE, 32'h00000012);
    settle;
    chk(32'h00000820, vectorPtr);
    ev(0, 32'h12345670);
    chk(32'h12345670, nmiRetPtr);
    chk(32'h00000880, {nmiEnable, vectorPtr[30:0]});
    ev(2, 32'h00000000);
    chk(32'h00000001, {31'h0, nmiEnable});
    wr(ivp_pkg::SEL_STATUS, 32'h00000001);
    settle;
    chk(32'h00000003, {30'h0, globalEnable, maskableReady});
    ev(1, 32'hABCD0120);
    chk(32'hABCD0120, intRetPtr);
    chk(32'h00000800, {globalEnable, maskableReady, vectorPtr[29:0]});
    ev(3, 32'h00000000);
    chk(32'h00000001, {31'h0, globalEnable});
    rd(ivp_pkg::SEL_STATUS);
    chk(32'h00000003, rdVal);
    wr(ivp_pkg::SEL_NMI_RET, 32'h00000A40);
    rd(ivp_pkg::SEL_NMI_RET);
    chk(32'h00000A40, rdVal);
    wr(ivp_pkg::SEL_INT_RET, 32'h00000B60);
    rd(ivp_pkg::SEL_INT_RET);
    chk(32'h00000B60, rdVal);
    chk(32'h00000B60, intRetPtr);
    wr(ivp_pkg::SEL_VTP, 32'hFFFFFFFF);
    settle;
    chk(32'hFFFFFC00, vectorPtr);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle;
    chk(32'h00000000, vectorPtr | resetEntryAddr | nmiRetPtr | intRetPtr);
    conclude;
  end
endmodule : tb
